// [pesd_pkg.sv]
// Constants and carrier types for the event-select decoder
package pesd_pkg;
    localparam int unsigned CNT_W   = 40;
    localparam int unsigned NUM_CNT = 2;
    localparam int unsigned SEL_W   = 16;
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned MASK_LSB = 8;

    localparam logic [7:0] EVT_INST_RET    = 8'hC0;
    localparam logic [7:0] EVT_UOPS_RET    = 8'hC2;
    localparam logic [7:0] EVT_INST_DEC    = 8'hD0;
    localparam logic [7:0] EVT_SIMD_RET    = 8'hD8;
    localparam logic [7:0] EVT_SIMD_COMP   = 8'hD9;
    localparam logic [7:0] EVT_HW_INT      = 8'hC8;
    localparam logic [7:0] EVT_IRQ_OFF     = 8'hC6;
    localparam logic [7:0] EVT_IRQ_OFF_PND = 8'hC7;
    localparam logic [7:0] EVT_BR_RET      = 8'hC4;
    localparam logic [7:0] EVT_BR_MISP     = 8'hC5;
    localparam logic [7:0] EVT_BR_TAKEN    = 8'hC9;
    localparam logic [7:0] EVT_BR_TK_MISP  = 8'hCA;
    localparam logic [7:0] EVT_BR_DEC      = 8'hE0;
    localparam logic [7:0] EVT_TGT_MISS    = 8'hE2;
    localparam logic [7:0] EVT_BOGUS       = 8'hE4;
    localparam logic [7:0] EVT_ADDR_CLR    = 8'hE6;
    localparam logic [7:0] EVT_RES_STALL   = 8'hA2;
    localparam logic [7:0] EVT_PART_STALL  = 8'hD2;
    localparam logic [7:0] EVT_SEG_LOAD    = 8'h06;
    localparam logic [7:0] EVT_UNHALTED    = 8'h79;

    localparam logic [7:0] MASK_ALL    = 8'h00;
    localparam logic [7:0] MASK_SCALAR = 8'h01;

    localparam logic [0:0] ADDR_SEL_A = 1'h0;
    localparam logic [0:0] ADDR_SEL_B = 1'h1;
    localparam logic [1:0] ADDR_CNT_A = 2'h0;
    localparam logic [1:0] ADDR_CNT_B = 2'h1;
    localparam logic [1:0] ADDR_SL_A  = 2'h2;
    localparam logic [1:0] ADDR_SL_B  = 2'h3;

    localparam logic [CNT_W-1:0] CNT_RST = 40'h00_0000_0000;
    localparam logic [SEL_W-1:0] SEL_RST = 16'h0000;
    localparam logic [3:0]       ONE4    = 4'h1;

    // Per-cycle activity from the core pipeline
    typedef struct packed {
        logic [2:0] instructions_retired_evt;
        logic [2:0] microops_retired_evt;
        logic [2:0] instructions_decoded_evt;
        logic [2:0] simd_retired;
        logic [2:0] simd_scalar_retired;
        logic [2:0] simd_comp_retired;
        logic [2:0] simd_comp_scalar_retired;
        logic       rep_store_irq;
        logic       halt_smi_resume;
        logic       hw_irq;
        logic       irq_disabled;
        logic       irq_pending;
        logic [1:0] br_retired;
        logic [1:0] br_misp_retired;
        logic [1:0] taken_retired_evt;
        logic [1:0] br_taken_misp_retired;
        logic [1:0] br_decoded;
        logic       tgt_miss;
        logic       bogus_branch;
        logic       branch_addr_clear;
        logic       resource_stall;
        logic       misp_recovery_stall;
        logic       sb_drain_stall;
        logic       partial_alias_stall;
        logic       seg_load;
        logic       halted;
    } pesd_core_evt_t;

    typedef struct packed {
        logic [3:0]       addr;
        logic [CNT_W-1:0] wdata;
        logic             wr;
        logic             rd;
    } pesd_bus_req_t;

    typedef struct packed {
        logic [NUM_CNT-1:0][SEL_W-1:0] sel;
        logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
        logic [CNT_W-1:0]              rdata;
    } pesd_state_t;
endpackage

// [pesd_event_counter.sv]
// Event-select decode and two performance counters
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
//
// Functional notes
// (RULE_01) Code C0, mask 00: add instructions retired per cycle.
// (RULE_02) Interrupt at last repeated string store iteration undercounts by one.
// (RULE_03) Sys-mgmt interrupt during halt leaves the resume uncounted.
// (RULE_04) Code D0, mask 00: add instructions decoded.
// (RULE_05) D8/D9 SIMD retired; mask 00 packed+scalar, 01 scalar; counters 0,1.
// (RULE_06) Code C8, mask 00: one per hardware interrupt received.
// (RULE_07) Code C6: one per cycle with interrupts disabled.
// (RULE_08) Code C7: one per cycle disabled and pending.
// (RULE_09) Code C4: add branches retired.
// (RULE_10) Code C5: add mispredicted branches retired.
// (RULE_11) Code C9: add taken branches retired.
// (RULE_12) Code CA: add taken and mispredicted branches retired.
// (RULE_13) Code E0: add branches decoded.
// (RULE_14) Code E2: one per branch with no target-buffer prediction.
// (RULE_15) Code E4: one per bogus branch.
// (RULE_16) Code E6: one per branch address clear assertion.
// (RULE_17) Code A2: one per resource-stall cycle.
// (RULE_18) Stall count includes mispredict recovery and store-buffer drain.
// (RULE_19) Code D2: one per partial alias stall.
// (RULE_20) Code 06, mask 00: one per segment register load.
// (RULE_21) Code 79: one per unhalted cycle.
// (RULE_22) Code and mask come from each counter's select register.
// (RULE_23) Unknown code adds nothing; counter holds when idle.
module pesd_event_counter
    import pesd_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  clk_en_in,
    input  wire pesd_bus_req_t         bus_in,
    input  wire pesd_core_evt_t        evt_in,
    output logic [CNT_W-1:0]           rdata_out,
    output logic [NUM_CNT-1:0][CNT_W-1:0] count_out
);

    pesd_state_t state_r;
    pesd_state_t state_nxt;
    // Unpacked so each decode process owns its own entry
    logic [3:0]  inc [NUM_CNT];

    // ----------------------------------------------------------------
    // Event decode, one per counter
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_CNT; g++)
        begin : g_dec
            logic [7:0] code;
            logic [7:0] mask;
            logic [3:0] adj;
            assign code = state_r.sel[g][CODE_LSB +: 8];  // RULE_22
            assign mask = state_r.sel[g][MASK_LSB +: 8];

            always_comb
            begin
                adj = 4'h0;
                // Core flags an instance the pipeline could not retire-count
                adj = {1'b0, evt_in.instructions_retired_evt} - {3'h0, evt_in.rep_store_irq}  // RULE_02
                      - {3'h0, evt_in.halt_smi_resume};                            // RULE_03
                if ({3'h0, evt_in.rep_store_irq} + {3'h0, evt_in.halt_smi_resume}
                    > {1'b0, evt_in.instructions_retired_evt})
                begin
                    adj = 4'h0;
                end
                inc[g] = 4'h0;  // RULE_23
                case (code)
                    EVT_INST_RET:
                        if (mask == MASK_ALL) inc[g] = adj;  // RULE_01
                    EVT_UOPS_RET:
                        if (mask == MASK_ALL) inc[g] = {1'b0, evt_in.microops_retired_evt};
                    EVT_INST_DEC:
                        if (mask == MASK_ALL) inc[g] = {1'b0, evt_in.instructions_decoded_evt};  // RULE_04
                    EVT_SIMD_RET:  // RULE_05
                        if (mask == MASK_ALL) inc[g] = {1'b0, evt_in.simd_retired};
                        else if (mask == MASK_SCALAR)
                            inc[g] = {1'b0, evt_in.simd_scalar_retired};
                    EVT_SIMD_COMP:  // RULE_05
                        if (mask == MASK_ALL) inc[g] = {1'b0, evt_in.simd_comp_retired};
                        else if (mask == MASK_SCALAR)
                            inc[g] = {1'b0, evt_in.simd_comp_scalar_retired};
                    EVT_HW_INT:
                        if (mask == MASK_ALL) inc[g] = {3'h0, evt_in.hw_irq};  // RULE_06
                    EVT_IRQ_OFF:
                        inc[g] = {3'h0, evt_in.irq_disabled};  // RULE_07
                    EVT_IRQ_OFF_PND:
                        inc[g] = {3'h0, evt_in.irq_disabled & evt_in.irq_pending};  // RULE_08
                    EVT_BR_RET:
                        inc[g] = {2'h0, evt_in.br_retired};  // RULE_09
                    EVT_BR_MISP:
                        inc[g] = {2'h0, evt_in.br_misp_retired};  // RULE_10
                    EVT_BR_TAKEN:
                        inc[g] = {2'h0, evt_in.taken_retired_evt};  // RULE_11
                    EVT_BR_TK_MISP:
                        inc[g] = {2'h0, evt_in.br_taken_misp_retired};  // RULE_12
                    EVT_BR_DEC:
                        inc[g] = {2'h0, evt_in.br_decoded};  // RULE_13
                    EVT_TGT_MISS:
                        inc[g] = {3'h0, evt_in.tgt_miss};  // RULE_14
                    EVT_BOGUS:
                        inc[g] = {3'h0, evt_in.bogus_branch};  // RULE_15
                    EVT_ADDR_CLR:
                        inc[g] = {3'h0, evt_in.branch_addr_clear};  // RULE_16
                    EVT_RES_STALL:  // RULE_17
                        inc[g] = {3'h0, evt_in.resource_stall
                                  | evt_in.misp_recovery_stall  // RULE_18
                                  | evt_in.sb_drain_stall};
                    EVT_PART_STALL:
                        inc[g] = {3'h0, evt_in.partial_alias_stall};  // RULE_19
                    EVT_SEG_LOAD:
                        if (mask == MASK_ALL) inc[g] = {3'h0, evt_in.seg_load};  // RULE_20
                    EVT_UNHALTED:
                        inc[g] = {3'h0, ~evt_in.halted};  // RULE_21
                    default:
                        inc[g] = 4'h0;  // RULE_23
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state: register writes win over counting in the same cycle
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        for (int i = 0; i < NUM_CNT; i++)
        begin
            state_nxt.cnt[i] = state_r.cnt[i] + {{(CNT_W-4){1'b0}}, inc[i]};
        end
        if (bus_in.wr)
        begin
            case (bus_in.addr[3:2])
                ADDR_CNT_A: state_nxt.cnt[0] = bus_in.wdata;
                ADDR_CNT_B: state_nxt.cnt[1] = bus_in.wdata;
                default:    state_nxt.sel[bus_in.addr[2]] = bus_in.wdata[SEL_W-1:0];
            endcase
        end
        state_nxt.rdata = CNT_RST;
        if (bus_in.rd)
        begin
            case (bus_in.addr[3:2])
                ADDR_CNT_A: state_nxt.rdata = state_r.cnt[0];
                ADDR_CNT_B: state_nxt.rdata = state_r.cnt[1];
                default:    state_nxt.rdata = {{(CNT_W-SEL_W){1'b0}},
                                               state_r.sel[bus_in.addr[2]]};
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            state_r <= '{sel: '{SEL_RST, SEL_RST}, cnt: '{CNT_RST, CNT_RST}, rdata: CNT_RST};
        end
        else if (clk_en_in)
        begin
            state_r <= state_nxt;
        end
    end

    assign rdata_out = state_r.rdata;
    assign count_out = state_r.cnt;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_idle0;
        clk_en_in && !bus_in.wr && inc[0] == 4'h0;
    endsequence

    hold_idle_a: assert property (s_idle0 |=> $stable(state_r.cnt[0]))  // RULE_23
        else $error("counter moved while idle");
    unhalted_cnt_a: assert property (clk_en_in && !bus_in.wr
        && state_r.sel[0][7:0] == EVT_UNHALTED && !evt_in.halted
        |=> state_r.cnt[0] == $past(state_r.cnt[0]) + 1)  // RULE_21
        else $error("unhalted cycle not counted");
    irq_off_a: assert property (state_r.sel[1][7:0] == EVT_IRQ_OFF
        |-> inc[1] == {3'h0, evt_in.irq_disabled})  // RULE_07
        else $error("disabled cycle miscount");
    pend_off_a: assert property (state_r.sel[0][7:0] == EVT_IRQ_OFF_PND && !evt_in.irq_pending
        |-> inc[0] == 4'h0)  // RULE_08
        else $error("counted without pending");
    inst_ret_a: assert property (state_r.sel[0] == {MASK_ALL, EVT_INST_RET}
        && !evt_in.rep_store_irq && !evt_in.halt_smi_resume
        |-> inc[0] == {1'b0, evt_in.instructions_retired_evt})  // RULE_01
        else $error("retired count wrong");
    rep_under_a: assert property (state_r.sel[0] == {MASK_ALL, EVT_INST_RET}
        && evt_in.rep_store_irq && !evt_in.halt_smi_resume && evt_in.instructions_retired_evt != 3'h0
        |-> inc[0] == {1'b0, evt_in.instructions_retired_evt} - ONE4)  // RULE_02
        else $error("string store undercount wrong");
    smi_under_a: assert property (state_r.sel[0] == {MASK_ALL, EVT_INST_RET}
        && evt_in.halt_smi_resume && !evt_in.rep_store_irq && evt_in.instructions_retired_evt != 3'h0
        |-> inc[0] == {1'b0, evt_in.instructions_retired_evt} - ONE4)  // RULE_03
        else $error("resume undercount wrong");
    simd_scal_a: assert property (state_r.sel[1] == {MASK_SCALAR, EVT_SIMD_RET}
        |-> inc[1] == {1'b0, evt_in.simd_scalar_retired})  // RULE_05
        else $error("scalar simd miscount");
    stall_a: assert property (state_r.sel[0][7:0] == EVT_RES_STALL && evt_in.sb_drain_stall
        |-> inc[0] == ONE4)  // RULE_18
        else $error("drain stall not counted");
    sel_write_a: assert property (clk_en_in && bus_in.wr && bus_in.addr[3:2] == ADDR_SL_A
        |=> state_r.sel[0] == $past(bus_in.wdata[SEL_W-1:0]))  // RULE_22
        else $error("select write lost");
endmodule

// [pesd_core_model.sv]
// Behavioural core pipeline that issues bursts of event activity
`timescale 1ns/10ps
module pesd_core_model
    import pesd_pkg::*;
(
    input  wire logic           sys_clk_in,
    input  wire logic           reset_in,
    input  wire logic           start_in,
    input  wire pesd_core_evt_t pat_in,
    input  wire logic [7:0]     len_in,
    output pesd_core_evt_t      evt_out
);
    pesd_core_evt_t idle;
    logic [7:0]     left_r;

    // Idle core sits halted, so cycle-based events stay quiet
    always_comb
    begin
        idle        = '0;
        idle.halted = 1'h1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || (!start_in && left_r == 8'h00))
        begin
            evt_out <= idle;
            left_r  <= 8'h00;
        end
        else if (start_in)
        begin
            evt_out <= pat_in;
            left_r  <= len_in - 8'h01;
        end
        else
        begin
            left_r  <= left_r - 8'h01;
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the event-select decoder
`timescale 1ns/10ps
module testbench
    import pesd_pkg::*;
;
    logic                          sys_clk;
    logic                          reset;
    logic                          start;
    logic                          clk_en;
    pesd_bus_req_t                 bus_r;
    pesd_core_evt_t                evt;
    pesd_core_evt_t                pat;
    pesd_core_evt_t                e;
    logic [CNT_W-1:0]              rdata;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    int                            n_mismatch;
    int                            cmp_count;
    int                            cyc;

    initial
    begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    pesd_event_counter uut (.sys_clk_in(sys_clk), .reset_in(reset), .clk_en_in(clk_en),
        .bus_in(bus_r), .evt_in(evt), .rdata_out(rdata), .count_out(cnt));
    pesd_core_model core_mdl (.sys_clk_in(sys_clk), .reset_in(reset), .start_in(start),
        .pat_in(pat), .len_in(8'h05), .evt_out(evt));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check_cnt(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t count got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [CNT_W-1:0] d);
        @(posedge sys_clk);
        bus_r <= '{a, d, 1'h1, 1'h0};
        @(posedge sys_clk);
        bus_r.wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, input logic [CNT_W-1:0] exp);
        @(posedge sys_clk);
        bus_r <= '{a, CNT_RST, 1'h0, 1'h1};
        @(posedge sys_clk);
        bus_r.rd <= 1'h0;
        #1 check_cnt(rdata, exp);
        @(posedge sys_clk);
        #1 check_cnt(rdata, CNT_RST);
    endtask

    function automatic pesd_core_evt_t mk(input logic [7:0] c, input logic [2:0] v);
        pesd_core_evt_t r;
        r = '0;
        r.halted = 1'h1;
        r.irq_pending = 1'h1;
        r.simd_scalar_retired = 3'h1;
        r.simd_comp_scalar_retired = 3'h1;
        case (c)
            EVT_INST_RET:                 r.instructions_retired_evt = v;
            EVT_INST_DEC:                 r.instructions_decoded_evt = v;
            EVT_SIMD_RET:                 r.simd_retired = v;
            EVT_SIMD_COMP:                r.simd_comp_retired = v;
            EVT_HW_INT:                   r.hw_irq = v[0];
            EVT_IRQ_OFF, EVT_IRQ_OFF_PND: r.irq_disabled = v[0];
            EVT_BR_RET:                   r.br_retired = v[1:0];
            EVT_BR_MISP:                  r.br_misp_retired = v[1:0];
            EVT_BR_TAKEN:                 r.taken_retired_evt = v[1:0];
            EVT_BR_TK_MISP:               r.br_taken_misp_retired = v[1:0];
            EVT_BR_DEC:                   r.br_decoded = v[1:0];
            EVT_TGT_MISS:                 r.tgt_miss = v[0];
            EVT_BOGUS:                    r.bogus_branch = v[0];
            EVT_ADDR_CLR:                 r.branch_addr_clear = v[0];
            EVT_RES_STALL:                r.resource_stall = v[0];
            EVT_PART_STALL:               r.partial_alias_stall = v[0];
            EVT_SEG_LOAD:                 r.seg_load = v[0];
            EVT_UNHALTED:                 r.halted = 1'h0;
            default:                      ;
        endcase
        return r;
    endfunction

    // Clear a counter, select an event, run a five-cycle burst, check the total
    task automatic run_case(input logic i, input logic [7:0] code, input logic [7:0] mask,
                            input pesd_core_evt_t ev, input logic [7:0] exp);
        bus_wr({1'h0, i, 2'h0}, CNT_RST);
        bus_wr({1'h1, i, 2'h0}, {24'h00_0000, mask, code});
        @(posedge sys_clk);
        pat   <= ev;
        start <= 1'h1;
        @(posedge sys_clk);
        start <= 1'h0;
        repeat (8) @(posedge sys_clk);
        #1 check_cnt(cnt[i], {32'h0000_0000, exp});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_retire();
        run_case(1'h0, EVT_INST_RET, MASK_ALL, mk(EVT_INST_RET, 3'h3), 8'h0F);
        e = mk(EVT_INST_RET, 3'h3);
        e.rep_store_irq = 1'h1;
        run_case(1'h1, EVT_INST_RET, MASK_ALL, e, 8'h0A);
        e = mk(EVT_INST_RET, 3'h3);
        e.halt_smi_resume = 1'h1;
        run_case(1'h0, EVT_INST_RET, MASK_ALL, e, 8'h0A);
        run_case(1'h1, EVT_INST_DEC, MASK_ALL, mk(EVT_INST_DEC, 3'h2), 8'h0A);
        run_case(1'h0, EVT_INST_RET, MASK_SCALAR, mk(EVT_INST_RET, 3'h3), 8'h00);
        $display("test_retire done");
    endtask

    task automatic test_simd_irq();
        run_case(1'h0, EVT_SIMD_RET, MASK_ALL, mk(EVT_SIMD_RET, 3'h3), 8'h0F);
        run_case(1'h1, EVT_SIMD_RET, MASK_SCALAR, mk(EVT_SIMD_RET, 3'h3), 8'h05);
        run_case(1'h1, EVT_SIMD_COMP, MASK_ALL, mk(EVT_SIMD_COMP, 3'h2), 8'h0A);
        run_case(1'h0, EVT_SIMD_COMP, MASK_SCALAR, mk(EVT_SIMD_COMP, 3'h2), 8'h05);
        run_case(1'h0, EVT_HW_INT, MASK_ALL, mk(EVT_HW_INT, 3'h1), 8'h05);
        run_case(1'h1, EVT_IRQ_OFF, MASK_ALL, mk(EVT_IRQ_OFF, 3'h1), 8'h05);
        run_case(1'h0, EVT_IRQ_OFF_PND, MASK_ALL, mk(EVT_IRQ_OFF, 3'h1), 8'h05);
        run_case(1'h1, EVT_IRQ_OFF_PND, MASK_ALL, mk(EVT_HW_INT, 3'h1), 8'h00);
        $display("test_simd_irq done");
    endtask

    task automatic test_branch();
        run_case(1'h0, EVT_BR_RET, MASK_ALL, mk(EVT_BR_RET, 3'h2), 8'h0A);
        run_case(1'h1, EVT_BR_MISP, MASK_ALL, mk(EVT_BR_MISP, 3'h1), 8'h05);
        run_case(1'h0, EVT_BR_TAKEN, MASK_ALL, mk(EVT_BR_TAKEN, 3'h3), 8'h0F);
        run_case(1'h1, EVT_BR_TK_MISP, MASK_ALL, mk(EVT_BR_TK_MISP, 3'h2), 8'h0A);
        run_case(1'h0, EVT_BR_DEC, MASK_ALL, mk(EVT_BR_DEC, 3'h3), 8'h0F);
        run_case(1'h1, EVT_TGT_MISS, MASK_ALL, mk(EVT_TGT_MISS, 3'h1), 8'h05);
        run_case(1'h0, EVT_BOGUS, MASK_ALL, mk(EVT_BOGUS, 3'h1), 8'h05);
        run_case(1'h1, EVT_ADDR_CLR, MASK_ALL, mk(EVT_ADDR_CLR, 3'h1), 8'h05);
        $display("test_branch done");
    endtask

    task automatic test_stall_misc();
        run_case(1'h0, EVT_RES_STALL, MASK_ALL, mk(EVT_RES_STALL, 3'h1), 8'h05);
        e = mk(EVT_SEG_LOAD, 3'h0);
        e.misp_recovery_stall = 1'h1;
        run_case(1'h1, EVT_RES_STALL, MASK_ALL, e, 8'h05);
        e.misp_recovery_stall = 1'h0;
        e.sb_drain_stall = 1'h1;
        run_case(1'h0, EVT_RES_STALL, MASK_ALL, e, 8'h05);
        run_case(1'h1, EVT_PART_STALL, MASK_ALL, mk(EVT_PART_STALL, 3'h1), 8'h05);
        run_case(1'h0, EVT_SEG_LOAD, MASK_ALL, mk(EVT_SEG_LOAD, 3'h1), 8'h05);
        run_case(1'h1, EVT_UNHALTED, MASK_ALL, mk(EVT_UNHALTED, 3'h1), 8'h05);
        run_case(1'h1, 8'h55, MASK_ALL, '1, 8'h00);
        bus_wr(4'h4, 40'h12_3456_789A);
        bus_rd(4'h4, 40'h12_3456_789A);
        $display("test_stall_misc done");
    endtask

    // Burst arrives while the enable is low: nothing may count
    task automatic test_freeze();
        bus_wr(4'h0, CNT_RST);
        bus_wr(4'h8, {24'h00_0000, MASK_ALL, EVT_UNHALTED});
        @(posedge sys_clk);
        clk_en <= 1'h0;
        pat    <= mk(EVT_UNHALTED, 3'h1);
        start  <= 1'h1;
        @(posedge sys_clk);
        start  <= 1'h0;
        repeat (8) @(posedge sys_clk);
        #1 check_cnt(cnt[0], CNT_RST);
        @(posedge sys_clk);
        clk_en <= 1'h1;
        $display("test_freeze done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial
    begin
        reset      = 1'h1;
        start      = 1'h0;
        clk_en     = 1'h1;
        bus_r      = '0;
        pat        = '0;
        e          = '0;
        n_mismatch = 0;
        cmp_count  = 0;
        cyc        = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'h0;
        test_retire();
        test_simd_irq();
        test_branch();
        test_stall_misc();
        test_freeze();
        print_verdict();
    end
endmodule
